/* File: core/dofrc_top.sv */
// How it works
// - Key 406 enters forcing; without forcing the mask has no effect.
// - While forcing, each output whose mask bit is set turns on.
// - Mask is volatile; after reset all outputs return to normal.
// - Key 400 ends forcing and restores function-mapped output control.
// - Forcing acts only while the drive is disabled; blocked when enabled.
// - Normal outputs take function and polarity from five configuration registers.
// - Mask shown in hex on display, fifth digit leading zero blanked.
//
// Added by the designer: register access over AHB-Lite and the register offsets.
module dofrc_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic servo_on,
   input wire logic [255:0] function_state,
   output logic [dofrc_pkg::DO_COUNT-1:0] digital_output,
   output logic [19:0] display_digits,
   output logic [4:0] display_blank
);
   import dofrc_pkg::*;

   logic [15:0] forcing_control_key;
   logic force_enable;
   logic [DO_COUNT-1:0] output_force_mask;
   logic [8:0] output_config [DO_COUNT];
   logic wr_pend;
   logic [7:0] wr_addr;
   dofrc_bus_t bus_state;
   dofrc_bus_t next_bus_state;

   wire logic addr_valid = hsel & hready & htrans[1];
   wire logic wr_now = bus_state == DOFRC_DATA && wr_pend;
   wire logic key_wr = wr_now && wr_addr == OFS_KEY;
   wire logic mask_wr = wr_now && wr_addr == OFS_MASK;
   wire logic force_active = force_enable & ~servo_on;
   logic [DO_COUNT-1:0] func_result;
   logic [DO_COUNT-1:0] polarity;
   logic [DO_COUNT-1:0] next_outputs;
   logic [31:0] next_rdata;

   function automatic logic cfg_hit(input logic [7:0] a, input int i);
      return a == OFS_CFG_FIRST + 8'(i * 4);
   endfunction : cfg_hit

   always_comb begin
      for (int i = 0; i < DO_COUNT; i++) begin
         func_result[i] = function_state[output_config[i][CFG_FUNC_W-1:CFG_FUNC_LSB]];
         polarity[i] = output_config[i][CFG_POL_BIT];
      end
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (haddr[7:0] == OFS_KEY) next_rdata = {16'h0000, forcing_control_key};
      else if (haddr[7:0] == OFS_MASK) next_rdata = {27'h0, output_force_mask};
      else if (haddr[7:0] == OFS_STATUS)
         next_rdata = {29'h0, force_active, servo_on, force_enable};
      else if (haddr[7:0] == OFS_DISPLAY) next_rdata = {12'h000, display_digits};
      for (int i = 0; i < DO_COUNT; i++)
         if (cfg_hit(haddr[7:0], i)) next_rdata = {23'h0, output_config[i]};
   end

   dofrc_outmux u_mux (
      .force_mask(output_force_mask),
      .force_active(force_active),
      .func_result(func_result),
      .polarity(polarity),
      .next_outputs(next_outputs)
   );

   // Back-to-back transfers stay in the data state; no wait states are ever added
   always_comb begin
      case (bus_state)
         DOFRC_IDLE: next_bus_state = addr_valid ? DOFRC_DATA : DOFRC_IDLE;
         DOFRC_DATA: next_bus_state = addr_valid ? DOFRC_DATA : DOFRC_IDLE;
         default: next_bus_state = DOFRC_IDLE;
      endcase
   end

   // Bus: zero-wait slave, read data registered at address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_state <= DOFRC_IDLE;
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata <= 32'h0000_0000;
      end else begin
         bus_state <= next_bus_state;
         wr_pend <= addr_valid & hwrite;
         wr_addr <= haddr[7:0];
         if (addr_valid && !hwrite) hrdata <= next_rdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         forcing_control_key <= RST_KEY;
         force_enable <= 1'b0;
      end else if (key_wr) begin
         forcing_control_key <= hwdata[15:0];
         if (hwdata[15:0] == KEY_FORCE_ON) force_enable <= 1'b1;
         else if (hwdata[15:0] == KEY_FORCE_OFF) force_enable <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) output_force_mask <= RST_MASK;
      else if (mask_wr) output_force_mask <= hwdata[DO_COUNT-1:0];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < DO_COUNT; i++) output_config[i] <= RST_CFG;
      end else begin
         for (int i = 0; i < DO_COUNT; i++)
            if (wr_now && cfg_hit(wr_addr, i)) output_config[i] <= hwdata[8:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) digital_output <= {DO_COUNT{1'b0}};
      else digital_output <= next_outputs;
   end

   // hex display, fifth digit blank when zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         display_digits <= 20'h00000;
         display_blank <= 5'h10;
      end else begin
         display_digits <= {15'h0000, output_force_mask};
         display_blank <= 5'h10;
      end
   end

   // Assertions
   chk_force_sets_out: assert property (
      @(posedge hclk) disable iff (!hresetn)
      force_active |=> digital_output == $past(output_force_mask))
      else $error("forced outputs differ from mask");
   chk_key_on: assert property (
      @(posedge hclk) disable iff (!hresetn)
      key_wr && hwdata[15:0] == KEY_FORCE_ON |=> force_enable)
      else $error("key 406 did not enable forcing");
   chk_key_off: assert property (
      @(posedge hclk) disable iff (!hresetn)
      key_wr && hwdata[15:0] == KEY_FORCE_OFF |=> !force_enable)
      else $error("key 400 did not end forcing");
   chk_servo_blocks: assert property (
      @(posedge hclk) disable iff (!hresetn)
      servo_on |=> digital_output == $past(func_result ^ polarity))
      else $error("forcing leaked while enabled");
   chk_mask_reset: assert property (
      @(posedge hclk) $rose(hresetn) |-> output_force_mask == RST_MASK && !force_enable)
      else $error("mask survived reset");
   chk_mask_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      mask_wr |=> output_force_mask == $past(hwdata[DO_COUNT-1:0]))
      else $error("mask write lost");
   chk_normal_map: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !force_enable |=> digital_output == $past(func_result ^ polarity))
      else $error("normal mapping wrong");
   chk_display_mask: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ##1 display_digits[4:0] == $past(output_force_mask) && display_blank[4])
      else $error("display does not show mask");
   // Other key values are stored but must leave the mode alone
   chk_key_other: assert property (
      @(posedge hclk) disable iff (!hresetn)
      key_wr && hwdata[15:0] != KEY_FORCE_ON && hwdata[15:0] != KEY_FORCE_OFF
      |=> force_enable == $past(force_enable))
      else $error("stray key changed forcing mode");
   chk_mask_hold: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !mask_wr |=> $stable(output_force_mask))
      else $error("mask changed without a write");
   chk_servo_status: assert property (
      @(posedge hclk) disable iff (!hresetn)
      servo_on |-> !force_active)
      else $error("forcing active while drive enabled");
   chk_ready_okay: assert property (
      @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> hreadyout && !hresp)
      else $error("bus not ready or not okay");
   sequence read_taken;
      addr_valid && !hwrite;
   endsequence
   chk_read_data: assert property (
      @(posedge hclk) disable iff (!hresetn)
      read_taken |=> hrdata == $past(next_rdata))
      else $error("read data not captured");
   // Read data must stand until the next read is taken
   chk_rdata_hold: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !(addr_valid && !hwrite) |=> $stable(hrdata))
      else $error("read data changed without a read");
endmodule : dofrc_top

/* File: core/dofrc_pkg.sv */
package dofrc_pkg;
   // Number of digital outputs
   localparam int DO_COUNT = 5;
   // Register byte offsets
   localparam logic [7:0] OFS_KEY = 8'h00;
   localparam logic [7:0] OFS_MASK = 8'h04;
   localparam logic [7:0] OFS_CFG_FIRST = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h1c;
   localparam logic [7:0] OFS_DISPLAY = 8'h20;
   // Key values
   localparam logic [15:0] KEY_FORCE_ON = 16'd406;
   localparam logic [15:0] KEY_FORCE_OFF = 16'd400;
   // Output configuration field layout: function code low, polarity bit
   localparam int CFG_FUNC_LSB = 0;
   localparam int CFG_FUNC_W = 8;
   localparam int CFG_POL_BIT = 8;
   // Reset values
   localparam logic [15:0] RST_KEY = 16'h0000;
   localparam logic [DO_COUNT-1:0] RST_MASK = 5'h00;
   localparam logic [8:0] RST_CFG = 9'h000;
   // Status bit positions
   localparam int ST_FORCE_EN = 0;
   localparam int ST_SERVO_ON = 1;
   localparam int ST_FORCE_ACT = 2;
   typedef enum logic [1:0] {
      DOFRC_IDLE,
      DOFRC_DATA
   } dofrc_bus_t;
endpackage : dofrc_pkg

/* File: core/dofrc_outmux.sv */
module dofrc_outmux (
   input wire logic [dofrc_pkg::DO_COUNT-1:0] force_mask,
   input wire logic force_active,
   input wire logic [dofrc_pkg::DO_COUNT-1:0] func_result,
   input wire logic [dofrc_pkg::DO_COUNT-1:0] polarity,
   output logic [dofrc_pkg::DO_COUNT-1:0] next_outputs
);
   import dofrc_pkg::*;
   wire logic [DO_COUNT-1:0] normal_level;
   assign normal_level = func_result ^ polarity;
   assign next_outputs = force_active ? force_mask : normal_level;
endmodule : dofrc_outmux

/* File: dv/dofrc_bench.sv */
module dofrc_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import dofrc_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, servo_on = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'd2;
   logic [255:0] function_state = '0;
   logic hreadyout, hresp, frc;
   logic [4:0] digital_output, display_blank, mask;
   logic [19:0] display_digits;
   logic [8:0] cfg [DO_COUNT];
   int n_mismatch, comparisons, cycles;
   dofrc_top dofrc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .servo_on(servo_on),
      .function_state(function_state), .digital_output(digital_output),
      .display_digits(display_digits), .display_blank(display_blank));
   always #10 hclk = ~hclk;
   task automatic test_done();
      $display("%0d mismatches in %0d comparisons", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   // Whole run needs well under a thousand cycles
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         test_done();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk
   // Signals are read just after the edge, so they still show pre-edge values
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus
   task automatic settle();
      repeat (3) @(posedge hclk);
   endtask : settle
   task automatic randfs();
      for (int i = 0; i < 8; i++) function_state[i*32 +: 32] <= $urandom;
   endtask : randfs
   function automatic logic [4:0] expect_out();
      logic [4:0] e;
      for (int n = 0; n < DO_COUNT; n++) begin
         e[n] = (frc && !servo_on) ? mask[n] : function_state[cfg[n][7:0]] ^ cfg[n][8];
      end
      return e;
   endfunction : expect_out
   task automatic clear_model();
      frc = 1'b0;
      mask = '0;
      foreach (cfg[k]) cfg[k] = '0;
   endtask : clear_model
   initial begin
      void'($urandom(32'h0a14297a));
      clear_model();
      randfs();
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      settle();
      chk(32'(display_blank), 32'h10);
      chk(32'(digital_output), 32'(expect_out()));
      $display("test reset done");
      for (int k = 0; k < DO_COUNT; k++) begin
         cfg[k] = 9'($urandom);
         bus(1'b1, OFS_CFG_FIRST + 8'(4 * k), 32'(cfg[k]));
         mask = 5'($urandom);
         bus(1'b1, OFS_MASK, 32'(mask));
         randfs();
         settle();
         chk(32'(digital_output), 32'(expect_out()));
      end
      $display("test normal done");
      bus(1'b1, OFS_KEY, 32'(KEY_FORCE_ON));
      frc = 1'b1;
      for (int i = 0; i < 4; i++) begin
         mask = (i == 0) ? 5'h05 : 5'($urandom);
         bus(1'b1, OFS_MASK, 32'(mask));
         randfs();
         settle();
         chk(32'(digital_output), 32'(expect_out()));
         chk(32'(display_digits), 32'(mask));
         chk(32'(display_blank[4]), 32'h1);
      end
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(q, 32'h5);
      chk(32'(hresp), 32'h0);
      bus(1'b1, OFS_KEY, 32'd401);
      bus(1'b0, OFS_KEY, 32'h0);
      chk(q, 32'd401);
      $display("test force done");
      servo_on <= 1'b1;
      settle();
      chk(32'(digital_output), 32'(expect_out()));
      servo_on <= 1'b0;
      settle();
      chk(32'(digital_output), 32'(expect_out()));
      bus(1'b1, OFS_KEY, 32'(KEY_FORCE_OFF));
      frc = 1'b0;
      settle();
      chk(32'(digital_output), 32'(expect_out()));
      bus(1'b1, OFS_KEY, 32'(KEY_FORCE_ON));
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      clear_model();
      settle();
      chk(32'(digital_output), 32'(expect_out()));
      bus(1'b0, OFS_MASK, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, 8'h40, 32'h0);
      chk(q, 32'h0);
      $display("test exit done");
      test_done();
   end
endmodule : dofrc_bench
